// [essc_top.sv]
// Function
// RQ1: Eight-bit up/down step counter for shifts, steps.
// RQ2: Load low operand buffer byte into counter.
// RQ3: Load is level driven and beats counting.
// RQ4: Counter bit five set counts up, else down.
// RQ5: Zero indication when counter bits five..zero clear.
// RQ6: Counting stops while zero indication is set.
// RQ7: Count pulse at end pulse, enabled, nonzero.
// RQ8: Left shift sets overflow when buffer 15/14 differ.
// RQ9: Overflow latches through its own OR path.
// RQ10: Overflow, carry clocks: enable gated with phases one/two.
// RQ11: Buffer clock: microword bit with phases one/three.
// RQ12: Pass phases one/two for shift register clocks.
// RQ13: Request flag clock from count-zero tests.
// RQ14: Flags hold sign, zero, overflow and carry.
// RQ15: Select fields pick each flag source.
// RQ16: Extra carry mux ORed, disables first carry half.
// RQ17: Counter, zero and flags driven outward.
// RQ18: Counter load strobe is enable gated by phases.
// RQ19: Reset clears counter and flags.
`timescale 1ns/1ps
module essc_top
   import essc_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire essc_uword_t uword_i,
   input wire essc_phase_t phase_i,
   input wire essc_cond_t cond_i,
   input wire logic [BR_W-1:0] operand_buffer_reg_i,
   input wire logic option_active_buffered_i,
   input wire logic count_zero_test_i,
   input wire logic [REG_AW-1:0] reg_addr_i,
   input wire logic [REG_DW-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [REG_DW-1:0] reg_rdata_o,
   output essc_flags_t ext_cond_flags_o,
   output logic [COUNT_W-1:0] step_count_o,
   output logic count_zero_o,
   output logic step_load_n_o,
   output logic overflow_flag_clock_o,
   output logic carry_flag_clock_o,
   output logic operand_buffer_clock_o,
   output logic phase_one_two_pulse_o,
   output logic request_flag_clock_n_o
);

   // ------------------------------------------------------------------
   // Types and state
   // ------------------------------------------------------------------
   typedef struct packed {
      essc_flags_t flags;
      logic req_en;
      logic [REG_DW-1:0] rdata;
      logic load_n;
      logic v_clk;
      logic c_clk;
      logic br_clk;
      logic p12;
      logic req_clk_n;
   } essc_state_t;

   essc_state_t s_q;
   essc_state_t s_d;

   function automatic logic essc_mux4(input logic [3:0] src, input logic [1:0] sel);
      essc_mux4 = src[sel];
   endfunction

   // ------------------------------------------------------------------
   // Strobes from microword enables and phase pulses
   // ------------------------------------------------------------------
   logic p12;
   logic load_now;
   logic count_now;
   logic [COUNT_W-1:0] count;
   logic count_zero;
   logic sign_change;
   logic [3:0] v_in;
   logic c_first;
   logic c_second;

   assign p12 = phase_i.p1 | phase_i.p2;                           // [RQ12]
   assign load_now = uword_i.load_en & p12;                        // [RQ18]
   assign count_now = uword_i.cnt_en & phase_i.p_end & ~count_zero; // [RQ7] [RQ6]

   essc_step_counter #(
      .WIDTH(COUNT_W),
      .ZBITS(ZERO_W),
      .DBIT(DIR_BIT)
   ) u_counter (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .load_i(load_now),
      .load_val_i(operand_buffer_reg_i[COUNT_W-1:0]),
      .count_en_i(count_now),
      .count_o(count),
      .zero_o(count_zero)
   );                                                              // [RQ1]

   // ------------------------------------------------------------------
   // Flag source multiplexers
   // ------------------------------------------------------------------
   // The sign-change forecast only counts during a left shift; the OR
   // with the current flag keeps overflow set for the rest of the shift.
   assign sign_change = (cond_i.shift_left &
                         (operand_buffer_reg_i[BR_SIGN_BIT] ^
                          operand_buffer_reg_i[BR_NEXT_BIT]))
                        | s_q.flags.v;                             // [RQ8] [RQ9]

   always_comb begin
      v_in = cond_i.v_src;
      v_in[V_SRC_SIGN_CHANGE] = sign_change;
   end

   // Select bit two enables the extra carry mux and blanks the first one.
   assign c_first = ~uword_i.carry_overflow_select[2] &
                    essc_mux4(cond_i.c_src, uword_i.carry_overflow_select[1:0]);   // [RQ16]
   assign c_second = uword_i.carry_overflow_select[2] &
                     essc_mux4(cond_i.c_extra, uword_i.carry_overflow_select[1:0]); // [RQ16]

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      if (uword_i.clk_nz && p12) begin
         s_d.flags.n = essc_mux4(cond_i.n_src, uword_i.sign_zero_select);  // [RQ14] [RQ15]
         s_d.flags.z = essc_mux4(cond_i.z_src, uword_i.sign_zero_select);  // [RQ14] [RQ15]
      end
      if (uword_i.clk_v && p12) begin
         s_d.flags.v = essc_mux4(v_in, uword_i.carry_overflow_select[1:0]); // [RQ15]
      end
      if (uword_i.clk_c && p12) begin
         s_d.flags.c = c_first | c_second;                         // [RQ14] [RQ16]
      end
      s_d.load_n = ~load_now;                                      // [RQ18]
      s_d.v_clk = uword_i.clk_v & p12;                             // [RQ10]
      s_d.c_clk = uword_i.clk_c & p12;                             // [RQ10]
      s_d.br_clk = uword_i.clk_br & (phase_i.p1 | phase_i.p3);     // [RQ11]
      s_d.p12 = p12;                                               // [RQ12]
      s_d.req_clk_n = ~(s_q.req_en & option_active_buffered_i &
                        count_zero_test_i);                        // [RQ13]
      if (reg_wr_i && reg_addr_i == REG_CTRL) begin
         s_d.req_en = reg_wdata_i[CTRL_REQ_EN_BIT];
      end
      s_d.rdata = '0;
      if (reg_rd_i) begin
         case (reg_addr_i)
            REG_CTRL: begin
               s_d.rdata[CTRL_REQ_EN_BIT] = s_q.req_en;
            end
            REG_FLAGS: begin
               s_d.rdata[4:0] = {count_zero, s_q.flags};
            end
            REG_COUNT: begin
               s_d.rdata = count;
            end
            default: begin
               s_d.rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         s_q.flags <= FLAGS_RST;                                   // [RQ19]
         s_q.req_en <= CTRL_RST;
         s_q.rdata <= '0;
         s_q.load_n <= 1'b1;
         s_q.v_clk <= 1'b0;
         s_q.c_clk <= 1'b0;
         s_q.br_clk <= 1'b0;
         s_q.p12 <= 1'b0;
         s_q.req_clk_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   // Counter and zero come from flops inside the counter; one cycle of
   // latency after a load is the price of a single synchronous clock.
   assign ext_cond_flags_o = s_q.flags;                            // [RQ17]
   assign step_count_o = count;                                    // [RQ17]
   assign count_zero_o = count_zero;                               // [RQ17]
   assign reg_rdata_o = s_q.rdata;
   assign step_load_n_o = s_q.load_n;
   assign overflow_flag_clock_o = s_q.v_clk;
   assign carry_flag_clock_o = s_q.c_clk;
   assign operand_buffer_clock_o = s_q.br_clk;
   assign phase_one_two_pulse_o = s_q.p12;
   assign request_flag_clock_n_o = s_q.req_clk_n;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   counter_load_a: assert property (load_now |=>   // [RQ2]
      step_count_o == $past(operand_buffer_reg_i[7:0]))
      else $error("counter did not take operand buffer low byte");

   load_priority_a: assert property ((load_now && uword_i.cnt_en) |=>   // [RQ3]
      step_count_o == $past(operand_buffer_reg_i[7:0]))
      else $error("count overrode load");

   count_dir_a: assert property ((count_now && !load_now && step_count_o[5]) |=>   // [RQ4]
      step_count_o == $past(step_count_o) + 8'h01)
      else $error("negative count did not increment");

   count_down_a: assert property ((count_now && !load_now && !step_count_o[5]) |=>   // [RQ1]
      step_count_o == $past(step_count_o) - 8'h01)
      else $error("positive count did not decrement");

   zero_flag_a: assert property (count_zero_o == (step_count_o[5:0] == 6'h00))   // [RQ5]
      else $error("zero indication wrong");

   count_stop_a: assert property ((count_zero_o && !load_now) |=>   // [RQ6]
      $stable(step_count_o))
      else $error("counter moved at zero");

   count_pulse_a: assert property ((!uword_i.cnt_en && !load_now) |=>   // [RQ7]
      $stable(step_count_o))
      else $error("counter moved without enable");

   overflow_set_a: assert property ((uword_i.clk_v && p12 && cond_i.shift_left &&   // [RQ8]
      uword_i.carry_overflow_select[1:0] == V_SRC_SIGN_CHANGE &&
      (operand_buffer_reg_i[15] != operand_buffer_reg_i[14])) |=> ext_cond_flags_o.v)
      else $error("sign change did not set overflow");

   overflow_hold_a: assert property ((ext_cond_flags_o.v && uword_i.clk_v &&   // [RQ9]
      uword_i.carry_overflow_select[1:0] == V_SRC_SIGN_CHANGE) |=> ext_cond_flags_o.v)
      else $error("overflow latch lost");

   flag_clock_a: assert property ((uword_i.clk_c && p12) |=> carry_flag_clock_o ##1   // [RQ10]
      (carry_flag_clock_o == $past(uword_i.clk_c && p12)))
      else $error("carry flag clock wrong");

   buffer_clock_a: assert property (operand_buffer_clock_o ==   // [RQ11]
      $past(uword_i.clk_br && (phase_i.p1 || phase_i.p3)))
      else $error("buffer clock wrong");

   load_strobe_a: assert property ((uword_i.load_en && phase_i.p2) |=> !step_load_n_o)   // [RQ18]
      else $error("load strobe missing");

   request_clock_a: assert property ((!s_q.req_en) |=> request_flag_clock_n_o)   // [RQ13]
      else $error("request clock while disabled");

   count_hold_a: assert property ((!count_now && !load_now) |=>   // [RQ7]
      $stable(step_count_o))
      else $error("counter moved without count pulse");

   // ------------------------------------------------------------------
   // Flag assertions
   // ------------------------------------------------------------------
   // A flag that moved between its own clocks would corrupt the condition
   // seen by the next microbranch, so each flag is held as well as loaded.

   sign_mux_a: assert property ((uword_i.clk_nz && p12) |=>   // [RQ15]
      ext_cond_flags_o.n == $past(cond_i.n_src[uword_i.sign_zero_select]))
      else $error("sign flag took wrong source");

   zero_mux_a: assert property ((uword_i.clk_nz && p12) |=>   // [RQ15]
      ext_cond_flags_o.z == $past(cond_i.z_src[uword_i.sign_zero_select]))
      else $error("zero flag took wrong source");

   sign_zero_hold_a: assert property (!(uword_i.clk_nz && p12) |=>   // [RQ14]
      $stable(ext_cond_flags_o.n) && $stable(ext_cond_flags_o.z))
      else $error("sign or zero flag moved without clock");

   overflow_mux_a: assert property ((uword_i.clk_v && p12 &&   // [RQ15]
      uword_i.carry_overflow_select[1:0] != V_SRC_SIGN_CHANGE) |=>
      ext_cond_flags_o.v == $past(cond_i.v_src[uword_i.carry_overflow_select[1:0]]))
      else $error("overflow flag took wrong source");

   overflow_keep_a: assert property (!(uword_i.clk_v && p12) |=>   // [RQ10]
      $stable(ext_cond_flags_o.v))
      else $error("overflow flag moved without clock");

   carry_first_a: assert property ((uword_i.clk_c && p12 &&   // [RQ16]
      !uword_i.carry_overflow_select[2]) |=>
      ext_cond_flags_o.c == $past(cond_i.c_src[uword_i.carry_overflow_select[1:0]]))
      else $error("carry flag ignored first mux");

   carry_extra_a: assert property ((uword_i.clk_c && p12 &&   // [RQ16]
      uword_i.carry_overflow_select[2]) |=>
      ext_cond_flags_o.c == $past(cond_i.c_extra[uword_i.carry_overflow_select[1:0]]))
      else $error("carry flag ignored extra mux");

   carry_keep_a: assert property (!(uword_i.clk_c && p12) |=>   // [RQ14]
      $stable(ext_cond_flags_o.c))
      else $error("carry flag moved without clock");

   // ------------------------------------------------------------------
   // Strobe assertions
   // ------------------------------------------------------------------
   // Every strobe is a registered copy one cycle late; the far side must
   // allow for that cycle when it lines the strobes up with its phases.

   overflow_clock_a: assert property (overflow_flag_clock_o ==   // [RQ10]
      $past(uword_i.clk_v && p12))
      else $error("overflow flag clock wrong");

   phase_pass_a: assert property (phase_one_two_pulse_o ==   // [RQ12]
      $past(phase_i.p1 || phase_i.p2))
      else $error("phase pulse not passed on");

   load_pulse_a: assert property (step_load_n_o ==   // [RQ18]
      !$past(uword_i.load_en && p12))
      else $error("load strobe wrong");

   request_pulse_a: assert property (request_flag_clock_n_o ==   // [RQ13]
      !$past(s_q.req_en && option_active_buffered_i && count_zero_test_i))
      else $error("request flag clock wrong");

   // ------------------------------------------------------------------
   // Register port assertions
   // ------------------------------------------------------------------

   count_read_a: assert property ((reg_rd_i && reg_addr_i == REG_COUNT) |=>   // [RQ17]
      reg_rdata_o == $past(step_count_o))
      else $error("count register read wrong");

   flags_read_a: assert property ((reg_rd_i && reg_addr_i == REG_FLAGS) |=>   // [RQ17]
      reg_rdata_o == {3'h0, $past(count_zero_o), $past(ext_cond_flags_o)})
      else $error("flags register read wrong");

   read_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)   // [RQ17]
      else $error("read data outside read cycle");

   load_seen_c: cover property (load_now ##[1:8] count_now);
   request_pulse_c: cover property (!request_flag_clock_n_o);
   count_to_zero_c: cover property (count_now ##1 count_zero_o);
   overflow_latched_c: cover property (ext_cond_flags_o.v ##1 uword_i.clk_v ##1 ext_cond_flags_o.v);
   extra_carry_c: cover property (uword_i.clk_c && p12 && uword_i.carry_overflow_select[2]);

endmodule

// [essc_pkg.sv]
package essc_pkg;

   // ------------------------------------------------------------------
   // Sizes and bit positions
   // ------------------------------------------------------------------
   localparam int COUNT_W = 8;
   localparam int ZERO_W = 6;
   localparam int DIR_BIT = 5;
   localparam int BR_W = 16;
   localparam int BR_SIGN_BIT = 15;
   localparam int BR_NEXT_BIT = 14;

   // ------------------------------------------------------------------
   // Values after reset
   // ------------------------------------------------------------------
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [3:0] FLAGS_RST = 4'h0;
   localparam logic CTRL_RST = 1'b0;

   // ------------------------------------------------------------------
   // Register port map and fields
   // ------------------------------------------------------------------
   localparam int REG_AW = 2;
   localparam int REG_DW = 8;
   localparam logic [1:0] REG_CTRL = 2'h0;
   localparam logic [1:0] REG_FLAGS = 2'h1;
   localparam logic [1:0] REG_COUNT = 2'h2;
   localparam int CTRL_REQ_EN_BIT = 0;

   // Overflow multiplexer input that carries the sign-change latch.
   localparam logic [1:0] V_SRC_SIGN_CHANGE = 2'h1;

   // ------------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic n;
      logic z;
      logic v;
      logic c;
   } essc_flags_t;

   typedef struct packed {
      logic cnt_en;
      logic load_en;
      logic clk_v;
      logic clk_c;
      logic clk_nz;
      logic clk_br;
      logic [1:0] sign_zero_select;
      logic [2:0] carry_overflow_select;
   } essc_uword_t;

   typedef struct packed {
      logic p1;
      logic p2;
      logic p3;
      logic p_end;
   } essc_phase_t;

   typedef struct packed {
      logic [3:0] n_src;
      logic [3:0] z_src;
      logic [3:0] v_src;
      logic [3:0] c_src;
      logic [3:0] c_extra;
      logic shift_left;
   } essc_cond_t;

endpackage

// [essc_step_counter.sv]
`timescale 1ns/1ps
module essc_step_counter
   import essc_pkg::*;
#(
   parameter int WIDTH = COUNT_W,
   parameter int ZBITS = ZERO_W,
   parameter int DBIT = DIR_BIT
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic load_i,
   input wire logic [WIDTH-1:0] load_val_i,
   input wire logic count_en_i,
   output logic [WIDTH-1:0] count_o,
   output logic zero_o
);

   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic zero;
   } essc_cnt_state_t;

   essc_cnt_state_t s_q;
   essc_cnt_state_t s_d;

   always_comb begin
      s_d = s_q;
      if (load_i) begin
         s_d.count = load_val_i;                                   // [RQ2] [RQ3]
      end else if (count_en_i && !s_q.zero) begin                  // [RQ6]
         // Bit DBIT set means a negative shift count, so count up toward zero.
         if (s_q.count[DBIT]) begin                                // [RQ4]
            s_d.count = s_q.count + {{(WIDTH-1){1'b0}}, 1'b1};
         end else begin
            s_d.count = s_q.count - {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
      s_d.zero = (s_d.count[ZBITS-1:0] == '0);                     // [RQ5]
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         s_q.count <= COUNT_RST[WIDTH-1:0];                        // [RQ19]
         s_q.zero <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign count_o = s_q.count;
   assign zero_o = s_q.zero;

endmodule

// [essc_host_model.sv]
`timescale 1ns/1ps
module essc_host_model
   import essc_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   output essc_phase_t phase_o
);
   // The host steps through a fixed four-slot microcycle: p1, p2, p3, end.
   logic [1:0] slot_q;
   logic run_q;
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         slot_q <= 2'h0;
         run_q <= 1'b0;
      end else begin
         run_q <= 1'b1;
         if (run_q) begin
            slot_q <= slot_q + 2'h1;
         end
      end
   end
   // One end pulse closes every microcycle.
   assign phase_o = {run_q && slot_q == 2'h0,
                     run_q && slot_q == 2'h1,
                     run_q && slot_q == 2'h2,
                     run_q && slot_q == 2'h3};
endmodule

// [essc_top_tb.sv]
`timescale 1ns/1ps
module essc_top_tb
   import essc_pkg::*;
();
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   essc_uword_t uw = '0;
   essc_phase_t ph;
   essc_cond_t cond = '0;
   logic [15:0] ob = 16'h0000;
   logic opt = 1'b0;
   logic czt = 1'b0;
   logic [1:0] raddr = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata, cnt, d;
   essc_flags_t flags;
   logic czero, ldn, vclk, cclk, brclk, p12, reqn, ev;
   int errors = 0;
   int cmp_count = 0;
   int tick = 0;
   logic [7:0] lv [3] = '{8'h03, 8'h3d, 8'hc2};
   logic [7:0] c1 [3] = '{8'h02, 8'h3e, 8'hc1};
   logic [7:0] cf [3] = '{8'h00, 8'h40, 8'hc0};

   essc_host_model host (.clk_i(clk_i), .nrst_i(nrst_i), .phase_o(ph));
   essc_top DUT (.clk_i(clk_i), .nrst_i(nrst_i), .uword_i(uw), .phase_i(ph),
      .cond_i(cond), .operand_buffer_reg_i(ob), .option_active_buffered_i(opt),
      .count_zero_test_i(czt), .reg_addr_i(raddr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .ext_cond_flags_o(flags),
      .step_count_o(cnt), .count_zero_o(czero), .step_load_n_o(ldn),
      .overflow_flag_clock_o(vclk), .carry_flag_clock_o(cclk),
      .operand_buffer_clock_o(brclk), .phase_one_two_pulse_o(p12),
      .request_flag_clock_n_o(reqn));

   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   always @(posedge clk_i) begin
      tick++;
      if (tick == 5000) begin
         errors++;
         end_of_test();
      end
   end

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Returns at the edge that samples the end pulse of a microcycle.
   task automatic micro(input int n);
      repeat (n) begin
         do @(posedge clk_i); while (ph.p_end !== 1'b1);
      end
   endtask

   task automatic reg_wr(input logic [1:0] a, input logic [7:0] v);
      raddr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [1:0] a, output logic [7:0] v);
      raddr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      @(posedge clk_i);
      v = rdata;
   endtask

   task automatic fstep(input logic [2:0] s);
      uw.carry_overflow_select <= s;
      uw.sign_zero_select <= s[1:0];
      micro(1);
      #1;
      if (s[1:0] == V_SRC_SIGN_CHANGE) begin
         ev = (cond.shift_left & (ob[15] ^ ob[14])) | ev;
      end else begin
         ev = cond.v_src[s[1:0]];
      end
      chk("flags", {4'h0, flags}, {4'h0, cond.n_src[s[1:0]], cond.z_src[s[1:0]], ev,
         s[2] ? cond.c_extra[s[1:0]] : cond.c_src[s[1:0]]});
   endtask

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      #1;
      chk("count", cnt, 8'h00);
      chk("status", {2'h0, czero, ldn, reqn, flags == 4'h0, vclk, p12}, 8'h3c);
      for (int a = 0; a < 4; a++) begin
         reg_rd(a[1:0], d);
         chk("reg", d, (a == 1) ? 8'h10 : 8'h00);
      end
      $display("test reset done");

      for (int i = 0; i < 3; i++) begin
         ob <= {8'hff, lv[i]};
         uw.load_en <= 1'b1;
         uw.cnt_en <= 1'b0;
         micro(1);
         #1;
         chk("load", cnt, lv[i]);
         chk("zero", {7'h0, czero}, {7'h0, lv[i][5:0] == 6'h00});
         uw.load_en <= 1'b0;
         uw.cnt_en <= 1'b1;
         micro(1);
         @(posedge clk_i);
         #1;
         chk("step", cnt, c1[i]);
         micro(3);
         @(posedge clk_i);
         #1;
         chk("stop", cnt, cf[i]);
         chk("zero", {7'h0, czero}, 8'h01);
         uw.cnt_en <= 1'b0;
      end
      reg_wr(REG_COUNT, 8'h55);
      reg_rd(REG_COUNT, d);
      chk("count read", d, 8'hc0);
      $display("test counter done");

      for (int en = 1; en >= 0; en--) begin
         uw.load_en <= en[0];
         uw.cnt_en <= en[0];
         uw.clk_v <= en[0];
         uw.clk_c <= en[0];
         uw.clk_br <= en[0];
         micro(1);
         for (int j = 0; j < 4; j++) begin
            @(posedge clk_i);
            #1;
            chk("strobes", {3'h0, p12, vclk, cclk, brclk, ldn}, {3'h0, j < 2,
               en[0] && j < 2, en[0] && j < 2, en[0] && (j == 0 || j == 2),
               !(en[0] && j < 2)});
         end
      end
      $display("test strobes done");

      cond <= '{n_src: 4'h6, z_src: 4'h9, v_src: 4'h9, c_src: 4'h3, c_extra: 4'h5,
         shift_left: 1'b0};
      uw.clk_nz <= 1'b1;
      uw.clk_v <= 1'b1;
      uw.clk_c <= 1'b1;
      ev = 1'b0;
      for (int s = 0; s < 8; s++) begin
         fstep(s[2:0]);
      end
      fstep(3'h2);
      cond.shift_left <= 1'b1;
      ob <= 16'h4000;
      fstep(3'h1);
      ob <= 16'hc000;
      fstep(3'h1);
      reg_rd(REG_FLAGS, d);
      chk("flags read", d, 8'h0b);
      $display("test flags done");

      nrst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      #1;
      chk("rst count", cnt, 8'h00);
      chk("rst flags", {3'h0, czero, flags}, 8'h10);
      $display("test reset again done");

      opt <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         czt <= 1'b1;
         @(posedge clk_i);
         czt <= 1'b0;
         #1;
         chk("req clock", {7'h0, reqn}, {7'h0, k == 0});
         @(posedge clk_i);
         #1;
         chk("req idle", {7'h0, reqn}, 8'h01);
         reg_wr(REG_CTRL, 8'h01);
      end
      reg_rd(REG_CTRL, d);
      chk("ctrl", d, 8'h01);
      $display("test request clock done");
      end_of_test();
   end
endmodule
